//--- common/stage_ctrl_pkg.sv
package stage_ctrl_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	localparam int START_DELAY_NS = 1000;
	localparam int START_DELAY_CYC =
		(START_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int MUTE_TIME_US = 100;
	localparam int MUTE_TIME_CYC =
		(MUTE_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int MUTE_HALF_NS = 1300;
	localparam int MUTE_HALF_CYC =
		(MUTE_HALF_NS * 1000) / CLK_PERIOD_PS;
	localparam int TIMER_W = 24;

	// ------------------------------------------------------------
	// Register map of the controller
	// ------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_FAULT = 4'h8;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_RAMP = 1;
	localparam int CTRL_MODE_LSB = 2;
	localparam int CTRL_LEVEL = 5;
	localparam logic [5:0] CTRL_RESET = 6'h00;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_SUPPLY_GOOD = 3;
	localparam int STAT_SUPPLY_HIGH = 4;
	localparam int STAT_FLAG_LSB = 5;
	localparam int FAULT_THERMAL_WARN = 0;
	localparam int FAULT_UV_THERMAL = 1;
	localparam int FAULT_OC_A = 2;
	localparam int FAULT_OC_B = 3;

	// ------------------------------------------------------------
	// Mode select codes of the power stage
	// ------------------------------------------------------------
	localparam logic [2:0] MODE_STEREO_FULL = 3'h0;
	localparam logic [2:0] MODE_RESERVED = 3'h7;

	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_SETTLE = 3'b001,
		ST_RUN = 3'b010,
		ST_MUTE = 3'b011,
		ST_DOWN = 3'b100
	} seq_state_type;

	typedef struct packed {
		logic pair_a_reset_n;
		logic pair_b_reset_n;
		logic ramp_enable;
		logic [2:0] mode_select;
		logic logic_level_select;
		logic [3:0] pwm_drive_in;
	} stage_pins_type;

	localparam stage_pins_type PINS_RESET = '{
		pair_a_reset_n: 1'b0,
		pair_b_reset_n: 1'b0,
		ramp_enable: 1'b0,
		mode_select: 3'h0,
		logic_level_select: 1'b0,
		pwm_drive_in: 4'h0
	};

endpackage : stage_ctrl_pkg

//--- hdl/mute_square.sv
module mute_square
	import stage_ctrl_pkg::*;
#(
	parameter int HALF_CYC = MUTE_HALF_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_enable,
	output logic o_square
);

	// ------------------------------------------------------------
	// Fifty percent square wave used as the mute pattern
	// ------------------------------------------------------------
	initial begin
		if (HALF_CYC < 1 || HALF_CYC > 65535) begin
			$error("mute_square: HALF_CYC out of range");
		end
	end

	logic [15:0] count;

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count <= 16'h0000;
		end else if (!i_enable || count == 16'(HALF_CYC - 1)) begin
			count <= 16'h0000;
		end else begin
			count <= count + 16'h0001;
		end
	end

	// Equal high and low halves keep the bridge at mid-supply on average.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_square <= 1'b0;
		end else if (!i_enable) begin
			o_square <= 1'b0;
		end else if (count == 16'(HALF_CYC - 1)) begin
			o_square <= !o_square;
		end
	end

endmodule : mute_square

//--- hdl/stage_sequencer.sv
module stage_sequencer
	import stage_ctrl_pkg::*;
#(
	parameter int MUTE_CYC = MUTE_TIME_CYC,
	parameter int SETTLE_CYC = START_DELAY_CYC,
	parameter int HALF_CYC = MUTE_HALF_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic [3:0] i_mod_pwm,
	input wire logic i_supply_good,
	input wire logic i_supply_above_12v,
	input wire logic i_thermal_warning_flag_n,
	input wire logic i_undervoltage_thermal_error_n,
	input wire logic i_pair_a_overcurrent_n,
	input wire logic i_pair_b_overcurrent_n,
	output stage_pins_type o_pins,
	output logic o_system_power_hold,
	output logic o_modulator_start
);

	// ------------------------------------------------------------
	// Parameter checks
	// ------------------------------------------------------------
	initial begin
		if (MUTE_CYC < 1 || MUTE_CYC >= (1 << TIMER_W)) begin
			$error("stage_sequencer: MUTE_CYC out of range");
		end
		if (SETTLE_CYC < 1 || SETTLE_CYC >= (1 << TIMER_W)) begin
			$error("stage_sequencer: SETTLE_CYC out of range");
		end
	end

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [5:0] sync_meta;
	logic [5:0] sync_pin;

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync_meta <= 6'h00;
			sync_pin <= 6'h00;
		end else begin
			sync_meta <= {i_supply_above_12v, i_supply_good,
				!i_pair_b_overcurrent_n, !i_pair_a_overcurrent_n,
				!i_undervoltage_thermal_error_n,
				!i_thermal_warning_flag_n};
			sync_pin <= sync_meta;
		end
	end

	logic [3:0] flag_live;
	logic supply_good;
	logic supply_high;

	assign flag_live = sync_pin[3:0];
	assign supply_good = sync_pin[4];
	assign supply_high = sync_pin[5];

	// ------------------------------------------------------------
	// Control and fault registers
	// ------------------------------------------------------------
	logic [5:0] ctrl;
	logic [3:0] fault;
	logic wr_ctrl;
	logic wr_fault;

	assign wr_ctrl = i_wr && i_addr == REG_CTRL;
	assign wr_fault = i_wr && i_addr == REG_FAULT;

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl <= CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl <= i_wdata[5:0];
		end
	end

	// A flag seen in the clearing cycle stays set.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fault <= 4'h0;
		end else begin
			fault <= (fault & ~(wr_fault ? i_wdata[3:0] : 4'h0))
				| flag_live;
		end
	end

	// ------------------------------------------------------------
	// Power sequence
	// ------------------------------------------------------------
	seq_state_type state;
	seq_state_type next_state;
	logic [TIMER_W-1:0] timer;
	logic timer_done;
	logic run_req;

	assign run_req = ctrl[CTRL_RUN];
	assign timer_done = timer == '0;

	always_comb begin
		next_state = state;
		unique case (state)
			ST_OFF: begin
				if (supply_good && run_req) begin
					next_state = ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				if (!run_req) begin
					next_state = ST_OFF;
				end else if (timer_done) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!run_req) begin
					next_state = ST_MUTE;
				end
			end
			ST_MUTE: begin
				if (timer_done) begin
					next_state = ST_DOWN;
				end
			end
			ST_DOWN: begin
				if (run_req) begin
					next_state = ST_OFF;
				end
			end
			default: begin
				next_state = ST_OFF;
			end
		endcase
		// Losing the supply drops the stage at once, without muting.
		if (!supply_good && state != ST_DOWN) begin
			next_state = ST_OFF;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= ST_OFF;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			timer <= '0;
		end else if (next_state != state) begin
			if (next_state == ST_SETTLE) begin
				timer <= TIMER_W'(SETTLE_CYC - 1);
			end else if (next_state == ST_MUTE) begin
				timer <= TIMER_W'(MUTE_CYC - 1);
			end else begin
				timer <= '0;
			end
		end else if (!timer_done) begin
			timer <= timer - 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Mute pattern
	// ------------------------------------------------------------
	logic mute_wave;

	mute_square #(
		.HALF_CYC(HALF_CYC)
	) u_mute (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_enable(state == ST_MUTE),
		.o_square(mute_wave)
	);

	// ------------------------------------------------------------
	// Stage pins
	// ------------------------------------------------------------
	logic resets_high;
	logic [2:0] mode_held;

	assign resets_high = state == ST_SETTLE || state == ST_RUN
		|| state == ST_MUTE;

	// Mode is taken only while the stage sits in reset.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mode_held <= MODE_STEREO_FULL;
		end else if (!resets_high) begin
			mode_held <= ctrl[CTRL_MODE_LSB +: 3];
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pins <= PINS_RESET;
		end else begin
			o_pins.pair_a_reset_n <= resets_high;
			o_pins.pair_b_reset_n <= resets_high;
			o_pins.ramp_enable <= ctrl[CTRL_RAMP]
				&& !supply_high;
			o_pins.mode_select <= mode_held;
			o_pins.logic_level_select <= ctrl[CTRL_LEVEL];
			// PWM stays low until run so no edge wakes an output early.
			if (state == ST_RUN) begin
				o_pins.pwm_drive_in <= i_mod_pwm;
			end else if (state == ST_MUTE) begin
				o_pins.pwm_drive_in <= {4{mute_wave}};
			end else begin
				o_pins.pwm_drive_in <= 4'h0;
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_system_power_hold <= 1'b1;
			o_modulator_start <= 1'b0;
		end else begin
			// Power is let go on the edge that drops the pair resets.
			o_system_power_hold <= state != ST_DOWN;
			o_modulator_start <= state == ST_RUN;
		end
	end

	// ------------------------------------------------------------
	// Register read
	// ------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= 32'h0000_0000;
		end else if (i_rd) begin
			unique case (i_addr)
				REG_CTRL: o_rdata <= {26'h0, ctrl};
				REG_STATUS: o_rdata <= {23'h0, flag_live, supply_high,
					supply_good, state};
				REG_FAULT: o_rdata <= {28'h0, fault};
				default: o_rdata <= 32'h0000_0000;
			endcase
		end else begin
			o_rdata <= 32'h0000_0000;
		end
	end

endmodule : stage_sequencer

//--- tb/stage_model.sv
module stage_model
	import stage_ctrl_pkg::*;
#(
	parameter int RAMP_NS = 200
) (
	input wire stage_pins_type i_pins,
	input wire logic [3:0] i_fault,
	output wire logic [3:0] o_drive_en,
	output wire logic [3:0] o_drive,
	output wire logic [3:0] o_flag_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Power stage behaviour
	// ------------------------------------------------------------
	wire logic [3:0] rst_n;
	wire logic [1:0] trip;
	logic [3:0] armed;
	logic [3:0] ramping;
	logic [3:0] inv;
	assign rst_n = {{2{i_pins.pair_b_reset_n}}, {2{i_pins.pair_a_reset_n}}};
	assign trip = {i_fault[1] | i_fault[3], i_fault[1] | i_fault[2]};
	always_comb begin
		case (i_pins.mode_select)
			3'h4: inv = 4'hA;
			3'h5: inv = 4'h8;
			3'h6: inv = 4'hC;
			default: inv = 4'h0;
		endcase
	end
	for (genvar k = 0; k < 4; k++) begin : g_out
		always @(posedge i_pins.pwm_drive_in[k] or negedge rst_n[k]) begin
			armed[k] <= rst_n[k];
		end
		// A new request restarts the ramp; an older clear may end it early.
		always @(rst_n[k]) begin
			ramping[k] = i_pins.ramp_enable
				&& !(k > 1 && i_pins.mode_select inside {3'h1, 3'h5});
			ramping[k] <= #(RAMP_NS) 1'b0;
		end
		assign o_drive_en[k] = rst_n[k] && armed[k] && !ramping[k]
			&& !trip[k / 2];
		assign o_drive[k] = o_drive_en[k]
			&& (i_pins.pwm_drive_in[k] ^ inv[k]);
	end
	assign o_flag_n = ~i_fault;
endmodule : stage_model

//--- tb/stage_sequencer_chk.sv
module stage_sequencer_chk
	import stage_ctrl_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_supply_good,
	input wire logic i_supply_above_12v,
	input wire stage_pins_type o_pins,
	input wire logic o_system_power_hold,
	input wire logic o_modulator_start
);
	// ------------------------------------------------------------
	// Stage pin checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);
	logic up;
	assign up = o_pins.pair_a_reset_n;
	// Five samples leave room for the two-flop supply synchroniser.
	property p_ramp_hv; i_supply_above_12v [*5] |-> !o_pins.ramp_enable;
	endproperty
	a_ramp_hv: assert property (p_ramp_hv)
		else $error("ramp high above 12 V");
	property p_pwm_gate; o_pins.pwm_drive_in != 4'h0 |-> up;
	endproperty
	a_pwm_gate: assert property (p_pwm_gate)
		else $error("pwm while stage in reset");
	property p_settle; $rose(up) |->
		(o_pins.pwm_drive_in == 4'h0 && !o_modulator_start) [*3];
	endproperty
	a_settle: assert property (p_settle)
		else $error("pwm started with reset release");
	property p_pair; o_pins.pair_a_reset_n == o_pins.pair_b_reset_n;
	endproperty
	a_pair: assert property (p_pair)
		else $error("pair resets split");
	property p_hold; !o_system_power_hold |->
		!up && o_pins.pwm_drive_in == 4'h0;
	endproperty
	a_hold: assert property (p_hold)
		else $error("power dropped before reset");
	property p_mute; up && !o_modulator_start |->
		o_pins.pwm_drive_in inside {4'h0, 4'hF};
	endproperty
	a_mute: assert property (p_mute)
		else $error("mute not common square");
	property p_supply; !i_supply_good [*5] |-> !up;
	endproperty
	a_supply: assert property (p_supply)
		else $error("reset not held on supply loss");
	property p_mode; up && $past(up) |-> $stable(o_pins.mode_select);
	endproperty
	a_mode: assert property (p_mode)
		else $error("mode changed while running");
endmodule : stage_sequencer_chk

bind stage_sequencer stage_sequencer_chk u_chk (
	.i_clk_sys(i_clk_sys),
	.i_rst_n(i_rst_n),
	.i_supply_good(i_supply_good),
	.i_supply_above_12v(i_supply_above_12v),
	.o_pins(o_pins),
	.o_system_power_hold(o_system_power_hold),
	.o_modulator_start(o_modulator_start)
);

//--- tb/stage_sequencer_tb_top.sv
module stage_sequencer_tb_top
	import stage_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Bench
	// ------------------------------------------------------------
	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic [31:0] exp;
	} row_type;
	row_type rows [5] = '{'{4'h0, 32'h3E, 32'h3E}, '{4'h0, 32'h36, 32'h36},
		'{4'hC, 32'hFF, 32'h0}, '{4'h4, 32'hFF, 32'h8}, '{4'h8, 32'hF, 32'h0}};
	logic i_clk_sys = 1'b0;
	logic i_rst_n = 1'b0;
	logic [3:0] i_addr = 4'h0;
	logic [31:0] i_wdata = 32'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [3:0] i_mod_pwm = 4'h0;
	logic good = 1'b1;
	logic high = 1'b0;
	logic [3:0] fault = 4'h0;
	logic [31:0] o_rdata;
	stage_pins_type o_pins;
	logic hold;
	logic start;
	wire logic [3:0] drive_en;
	wire logic [3:0] flag_n;
	logic [31:0] rd_val;
	logic [3:0] p1;
	int errors = 0;
	int cmp_count = 0;
	int n;
	always #2.5 i_clk_sys = ~i_clk_sys;
	stage_sequencer #(.MUTE_CYC(20), .SETTLE_CYC(4), .HALF_CYC(2)) u_dut (
		.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_mod_pwm(i_mod_pwm), .i_supply_good(good),
		.i_supply_above_12v(high), .i_thermal_warning_flag_n(flag_n[0]),
		.i_undervoltage_thermal_error_n(flag_n[1]),
		.i_pair_a_overcurrent_n(flag_n[2]), .i_pair_b_overcurrent_n(flag_n[3]),
		.o_pins(o_pins), .o_system_power_hold(hold), .o_modulator_start(start));
	stage_model u_stage (.i_pins(o_pins), .i_fault(fault),
		.o_drive_en(drive_en), .o_drive(), .o_flag_n(flag_n));
	task automatic chk_reg(string nm, logic [31:0] e, logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_reg
	task automatic chk_bit(string nm, logic e, logic g);
		chk_reg(nm, {31'h0, e}, {31'h0, g});
	endtask : chk_bit
	task automatic wr(logic [3:0] a, logic [31:0] d);
		@(posedge i_clk_sys);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(logic [3:0] a);
		@(posedge i_clk_sys);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		#1 rd_val = o_rdata;
	endtask : rd
	task automatic report_and_stop();
		if (errors == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : report_and_stop
	task automatic wait_until(logic s);
		n = 0;
		while ((s ? start !== 1'b1 : hold !== 1'b0) && n < 400) begin
			@(posedge i_clk_sys);
			#1 n++;
		end
		if (n == 400) begin
			errors++;
			report_and_stop();
		end
	endtask : wait_until
	initial begin
		repeat (20) @(posedge i_clk_sys);
		#1 chk_reg("pins in reset", 32'(PINS_RESET), 32'(o_pins));
		@(posedge i_clk_sys) i_rst_n <= 1'b1;
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wdata);
			rd(rows[i].addr);
			chk_reg("row read", rows[i].exp, rd_val);
		end
		chk_reg("mode off", 32'h5, 32'(o_pins.mode_select));
		chk_bit("ramp on", 1'b1, o_pins.ramp_enable);
		wr(4'h0, 32'h17);
		wait_until(1'b1);
		rd(4'h4);
		chk_reg("status run", 32'hA, rd_val);
		@(posedge i_clk_sys) i_mod_pwm <= 4'h5;
		repeat (50) @(posedge i_clk_sys);
		#1 chk_reg("pwm", 32'h5, 32'(o_pins.pwm_drive_in));
		chk_reg("enables", 32'h5, 32'(drive_en));
		wr(4'h0, 32'h0F);
		@(posedge i_clk_sys) high <= 1'b1;
		repeat (6) @(posedge i_clk_sys);
		#1 chk_bit("ramp 12 V", 1'b0, o_pins.ramp_enable);
		chk_reg("mode held", 32'h5, 32'(o_pins.mode_select));
		rd(4'h4);
		chk_reg("status 12 V", 32'h1A, rd_val);
		high <= 1'b0;
		fault <= 4'hA;
		repeat (4) @(posedge i_clk_sys);
		rd(4'h4);
		chk_reg("live flags", 32'h14A, rd_val);
		fault <= 4'h0;
		repeat (4) @(posedge i_clk_sys);
		rd(4'h8);
		chk_reg("sticky flags", 32'hA, rd_val);
		wr(4'h8, 32'hF);
		rd(4'h8);
		chk_reg("cleared flags", 32'h0, rd_val);
		// Quiet input first so the mute square has a clean start.
		i_mod_pwm <= 4'h0;
		wr(4'h0, 32'h0E);
		repeat (3) @(posedge i_clk_sys);
		#1 p1 = o_pins.pwm_drive_in;
		repeat (2) @(posedge i_clk_sys);
		#1 chk_reg("mute", {28'h0, ~p1}, 32'(o_pins.pwm_drive_in));
		chk_bit("up in mute", 1'b1, o_pins.pair_a_reset_n);
		wait_until(1'b0);
		chk_reg("down", 32'h0, 32'({o_pins[10:9], o_pins[3:0]}));
		wr(4'h0, 32'h0F);
		wait_until(1'b1);
		chk_reg("mode new", 32'h3, 32'(o_pins.mode_select));
		good <= 1'b0;
		repeat (6) @(posedge i_clk_sys);
		#1 chk_bit("up on loss", 1'b0, o_pins.pair_a_reset_n);
		rd(4'h4);
		chk_reg("status loss", 32'h0, rd_val);
		good <= 1'b1;
		wait_until(1'b1);
		@(posedge i_clk_sys) i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
		#1 chk_reg("pins mid reset", 32'(PINS_RESET), 32'(o_pins));
		@(posedge i_clk_sys) i_rst_n <= 1'b1;
		repeat (4) @(posedge i_clk_sys);
		#1 chk_reg("pins after reset", 32'(PINS_RESET), 32'(o_pins));
		chk_bit("hold after reset", 1'b1, hold);
		rd(4'h0);
		chk_reg("ctrl after reset", 32'h0, rd_val);
		report_and_stop();
	end
endmodule : stage_sequencer_tb_top
